/* include/frame_preemption_merge_regs.svh */
// constants for the frame preemption and interspersing block
// Summary of operation
// - verify partner before preemption when allowed
// - preemption active after success or inhibit
// - send preemptable frames when express idle
// - express wins simultaneous requests
// - cut preemptable frame under allow formula
// - resume interrupted frame after express done
// - inter-frame gap keeps source ready low
// - steer received frames by type
// - reassemble preemptable receive fragments
// - preemptable valid may gap between fragments
// - tlast ends reassembly, tuser marks failure
// - first allow starts verify if status zero
// - hold request withholds preemptable traffic
// - restart rising edge starts new verify
// - decode minimum remaining fragment size
// - verify timeout in milliseconds, default one
// - verify attempt limit, default three
// - status bit0 complete, bit1 success
// - pulse initial and continuation fragment sent
// - hold indication on hold rising edge
// - reject wrong or orphan start delimiter
// - receive fault, done, fragment indications
`ifndef FRAME_PREEMPTION_MERGE_REGS_SVH
`define FRAME_PREEMPTION_MERGE_REGS_SVH
`define CTRL_OFFSET       12'h000
`define STATUS_OFFSET     12'h004
`define CTRL_EN_BIT       0
`define CTRL_HOLD_BIT     1
`define CTRL_NOVERIFY_BIT 2
`define CTRL_RESTART_BIT  3
`define CTRL_FRAG_LSB     4
`define CTRL_TIME_LSB     8
`define CTRL_LIMIT_LSB    16
`define CTRL_RESET        32'h0003_0100
`define CLK_PERIOD_NS     5
`define VERIFY_UNIT_NS    1000000
`define IFG_CYCLES        4'h3
`define BEAT_BYTES        16'h0008
`define MIN_FRAG_BYTES    16'h0040
`endif

/* include/frame_preemption_merge_pkg.sv */
// types shared by the frame preemption and interspersing block
package frame_preemption_merge_pkg;
  typedef enum logic [2:0] {
    KIND_EXPRESS, KIND_START, KIND_CONT, KIND_VERIFY, KIND_RESPOND
  } frag_kind_type;
  typedef enum logic [1:0] {SRC_IDLE, SRC_EXP, SRC_PRE} tx_src_type;
  typedef enum logic [2:0] {V_OFF, V_SEND, V_WAIT, V_OK, V_FAIL} verify_fsm_type;
endpackage : frame_preemption_merge_pkg

/* src/frame_preemption_merge.sv */
// frame preemption transmit merge, verification and receive reassembly
//
// Chosen here: the register addresses and the APB slave port.
`include "frame_preemption_merge_regs.svh"
module frame_preemption_merge
  import frame_preemption_merge_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `VERIFY_UNIT_NS / `CLK_PERIOD_NS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [63:0] tx_e_tdata,
  input  wire logic        tx_e_tvalid,
  input  wire logic        tx_e_tlast,
  output logic             tx_e_tready,
  input  wire logic [63:0] tx_p_tdata,
  input  wire logic        tx_p_tvalid,
  input  wire logic        tx_p_tlast,
  input  wire logic [15:0] tx_p_frame_bytes,
  output logic             tx_p_tready,
  output logic      [63:0] tx_tdata,
  output logic             tx_tvalid,
  output logic             tx_tlast,
  output logic             tx_tuser,
  output logic      [2:0]  tx_kind,
  output logic      [1:0]  tx_frag_num,
  input  wire logic        tx_tready,
  input  wire logic [63:0] rx_tdata,
  input  wire logic        rx_tvalid,
  input  wire logic        rx_tlast,
  input  wire logic        rx_tuser,
  input  wire logic [2:0]  rx_kind,
  input  wire logic [1:0]  rx_frag_num,
  input  wire logic        rx_frag_final,
  output logic      [63:0] rx_e_tdata,
  output logic             rx_e_tvalid,
  output logic             rx_e_tlast,
  output logic             rx_e_tuser,
  output logic      [63:0] rx_p_tdata,
  output logic             rx_p_tvalid,
  output logic             rx_p_tlast,
  output logic             rx_p_tuser,
  output logic      [1:0]  verify_state,
  output logic             tx_preemptable_sent,
  output logic             tx_continuation_sent,
  output logic             tx_hold_seen,
  output logic             rx_reassembly_fault,
  output logic             rx_delimiter_reject,
  output logic             rx_reassembly_done,
  output logic             rx_fragment_seen
);

  logic [31:0]    ctrl_q;
  logic           en_prev_q, en_seen_q, hold_prev_q, restart_prev_q;
  verify_fsm_type vstate_q;
  logic [24:0]    vtimer_q;
  logic [3:0]     attempts_q;
  logic           resp_q;
  tx_src_type     cur_q;
  logic           p_open_q, p_cont_q;
  logic [1:0]     p_frag_q;
  logic [15:0]    p_total_q, p_sent_q;
  logic [3:0]     ifg_q;
  logic           rx_first_q, rx_asm_q, rx_discard_q;
  logic [1:0]     rx_exp_q;

  logic       en, hold, noverify, restart, preempt_active, start_verify, ver_load;
  logic [1:0] frag_sel;
  logic [7:0] vtime;
  logic [3:0] vlimit;
  assign en       = ctrl_q[`CTRL_EN_BIT];
  assign hold     = ctrl_q[`CTRL_HOLD_BIT];
  assign noverify = ctrl_q[`CTRL_NOVERIFY_BIT];
  assign restart  = ctrl_q[`CTRL_RESTART_BIT];
  assign frag_sel = ctrl_q[`CTRL_FRAG_LSB +: 2];
  assign vtime    = ctrl_q[`CTRL_TIME_LSB +: 8];
  assign vlimit   = ctrl_q[`CTRL_LIMIT_LSB +: 4];

  // APB slave: one wait state, unmapped offsets answer with an error
  logic apb_acc, ctrl_hit, stat_hit;
  assign apb_acc  = psel && penable && !pready;
  assign ctrl_hit = paddr == `CTRL_OFFSET;
  assign stat_hit = paddr == `STATUS_OFFSET;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_acc;
      pslverr <= apb_acc && !ctrl_hit && !stat_hit;
      prdata  <= 32'h0000_0000;
      if (apb_acc && !pwrite && ctrl_hit) begin
        prdata <= ctrl_q;
      end else if (apb_acc && !pwrite && stat_hit) begin
        prdata <= {27'h0, rx_asm_q, p_open_q, preempt_active, verify_state};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RESET;
    end else if (psel && penable && pready && pwrite && ctrl_hit) begin
      ctrl_q <= pwdata;
    end
  end

  // verification control
  logic [24:0] vtimeout;
  assign preempt_active = en && (noverify || vstate_q == V_OK);
  assign start_verify = !noverify && ((en && !en_seen_q && verify_state == 2'b00)
                        || (restart && !restart_prev_q));
  assign vtimeout = 25'(vtime * MS_CYCLES);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_prev_q      <= 1'b0;
      en_seen_q      <= 1'b0;
      hold_prev_q    <= 1'b0;
      restart_prev_q <= 1'b0;
      tx_hold_seen   <= 1'b0;
    end else begin
      en_prev_q      <= en;
      restart_prev_q <= restart;
      hold_prev_q    <= hold;
      if (en && !en_prev_q) begin
        en_seen_q <= 1'b1;
      end
      tx_hold_seen <= hold && !hold_prev_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vstate_q   <= V_OFF;
      vtimer_q   <= 25'h0;
      attempts_q <= 4'h0;
    end else begin
      // send, wait, retry up to the limit
      case (vstate_q)
        V_SEND: begin
          if (ver_load) begin
            vstate_q   <= V_WAIT;
            vtimer_q   <= vtimeout;
            attempts_q <= attempts_q + 4'h1;
          end
        end
        V_WAIT: begin
          if (resp_q) begin
            vstate_q <= V_OK;
          end else if (vtimer_q <= 25'h1) begin
            vstate_q <= (attempts_q >= vlimit) ? V_FAIL : V_SEND;
          end else begin
            vtimer_q <= vtimer_q - 25'h1;
          end
        end
        default: begin
        end
      endcase
      if (start_verify) begin
        vstate_q   <= V_SEND;
        attempts_q <= 4'h0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      verify_state <= 2'b00;
    end else begin
      case (vstate_q)
        V_OK:    verify_state <= 2'b11;
        V_FAIL:  verify_state <= 2'b01;
        default: verify_state <= 2'b00;
      endcase
      if (start_verify) begin
        verify_state <= 2'b00;
      end
    end
  end

  // transmit merge
  logic        e_load, p_load, out_free, out_free_next, frag_cut, out_last;
  logic [15:0] sent_after, min_remain;
  assign e_load   = tx_e_tready && tx_e_tvalid;
  assign p_load   = tx_p_tready && tx_p_tvalid;
  assign ver_load = vstate_q == V_SEND && cur_q == SRC_IDLE && out_free && ifg_q == 4'h0
                    && !tx_e_tready && !tx_p_tready;
  assign out_free = !tx_tvalid || tx_tready;
  assign out_free_next = out_free && !e_load && !p_load && !ver_load;
  assign min_remain = {8'h0, frag_sel, 6'h0} + `MIN_FRAG_BYTES;
  assign sent_after = (p_open_q ? p_sent_q : 16'h0) + `BEAT_BYTES;
  // cut only under the allow formula
  assign frag_cut = preempt_active && (tx_e_tvalid || hold) && !tx_p_tlast
                    && sent_after >= `MIN_FRAG_BYTES
                    && (p_open_q ? p_total_q : tx_p_frame_bytes) >= sent_after + min_remain;
  assign out_last = tx_p_tlast || frag_cut;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_e_tready <= 1'b0;
      tx_p_tready <= 1'b0;
    end else begin
      tx_e_tready <= 1'b0;
      tx_p_tready <= 1'b0;
      // no ready during the inter-frame gap
      if (out_free_next && ifg_q == 4'h0 && !(tx_tvalid && tx_tlast)) begin
        case (cur_q)
          SRC_EXP: tx_e_tready <= 1'b1;
          SRC_PRE: tx_p_tready <= !hold || p_open_q;
          default: begin
            if (vstate_q == V_SEND) begin
            end else if (tx_e_tvalid && !e_load) begin
              tx_e_tready <= 1'b1;
            // preemptable when express idle and no hold
            end else if (tx_p_tvalid && !hold && !p_load && (preempt_active || !p_open_q)) begin
              tx_p_tready <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_tdata    <= 64'h0;
      tx_tvalid   <= 1'b0;
      tx_tlast    <= 1'b0;
      tx_tuser    <= 1'b0;
      tx_kind     <= 3'h0;
      tx_frag_num <= 2'h0;
    end else begin
      if (tx_tvalid && tx_tready) begin
        tx_tvalid <= 1'b0;
      end
      if (e_load) begin
        tx_tdata  <= tx_e_tdata;
        tx_tvalid <= 1'b1;
        tx_tlast  <= tx_e_tlast;
        tx_tuser  <= 1'b0;
        tx_kind   <= KIND_EXPRESS;
      end else if (p_load) begin
        tx_tdata    <= tx_p_tdata;
        tx_tvalid   <= 1'b1;
        tx_tlast    <= out_last;
        tx_tuser    <= frag_cut;
        tx_kind     <= p_cont_q ? KIND_CONT : KIND_START;
        tx_frag_num <= p_frag_q;
      end else if (ver_load) begin
        tx_tdata  <= 64'h0;
        tx_tvalid <= 1'b1;
        tx_tlast  <= 1'b1;
        tx_tuser  <= 1'b0;
        tx_kind   <= KIND_VERIFY;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_q     <= SRC_IDLE;
      p_open_q  <= 1'b0;
      p_cont_q  <= 1'b0;
      p_frag_q  <= 2'h0;
      p_total_q <= 16'h0;
      p_sent_q  <= 16'h0;
    end else begin
      if (e_load) begin
        cur_q <= tx_e_tlast ? SRC_IDLE : SRC_EXP;
      end else if (p_load) begin
        cur_q    <= out_last ? SRC_IDLE : SRC_PRE;
        p_sent_q <= sent_after;
        if (!p_open_q) begin
          p_total_q <= tx_p_frame_bytes;
        end
        p_open_q <= !tx_p_tlast;
        if (tx_p_tlast) begin
          p_cont_q <= 1'b0;
          p_frag_q <= 2'h0;
        end else if (frag_cut) begin
          p_cont_q <= 1'b1;
          p_frag_q <= p_frag_q + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ifg_q                <= 4'h0;
      tx_preemptable_sent  <= 1'b0;
      tx_continuation_sent <= 1'b0;
    end else begin
      if (tx_tvalid && tx_tready && tx_tlast) begin
        ifg_q <= `IFG_CYCLES;
      end else if (ifg_q != 4'h0) begin
        ifg_q <= ifg_q - 4'h1;
      end
      tx_preemptable_sent  <= p_load && out_last && !p_cont_q;
      tx_continuation_sent <= p_load && out_last && p_cont_q;
    end
  end

  // receive steering and reassembly
  logic is_start, is_cont, rx_p_beat, fault_beat, orphan, bad_num, first_ok;
  assign is_start   = rx_kind == KIND_START;
  assign is_cont    = rx_kind == KIND_CONT;
  assign orphan     = rx_first_q && is_cont && !rx_asm_q;
  assign bad_num    = rx_first_q && is_cont && rx_asm_q && rx_frag_num != rx_exp_q;
  assign fault_beat = rx_first_q && is_start && rx_asm_q;
  assign first_ok   = rx_first_q && ((is_start && !rx_asm_q) || (is_cont && rx_asm_q && !bad_num));
  assign rx_p_beat  = rx_tvalid && (first_ok || (!rx_first_q && !rx_discard_q && (is_start || is_cont)));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_e_tdata  <= 64'h0;
      rx_e_tvalid <= 1'b0;
      rx_e_tlast  <= 1'b0;
      rx_e_tuser  <= 1'b0;
      resp_q      <= 1'b0;
    end else begin
      rx_e_tvalid <= rx_tvalid && rx_kind == KIND_EXPRESS;
      rx_e_tdata  <= rx_tdata;
      rx_e_tlast  <= rx_tlast;
      rx_e_tuser  <= rx_tuser;
      resp_q      <= rx_tvalid && rx_first_q && rx_kind == KIND_RESPOND;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_p_tdata          <= 64'h0;
      rx_p_tvalid         <= 1'b0;
      rx_p_tlast          <= 1'b0;
      rx_p_tuser          <= 1'b0;
      rx_first_q          <= 1'b1;
      rx_asm_q            <= 1'b0;
      rx_discard_q        <= 1'b0;
      rx_exp_q            <= 2'h0;
      rx_reassembly_fault <= 1'b0;
      rx_delimiter_reject <= 1'b0;
      rx_reassembly_done  <= 1'b0;
      rx_fragment_seen    <= 1'b0;
    end else begin
      rx_p_tvalid         <= 1'b0;
      rx_p_tlast          <= 1'b0;
      rx_p_tuser          <= 1'b0;
      rx_reassembly_fault <= 1'b0;
      rx_delimiter_reject <= 1'b0;
      rx_reassembly_done  <= 1'b0;
      rx_fragment_seen    <= 1'b0;
      if (rx_tvalid) begin
        rx_first_q <= rx_tlast;
        if (rx_first_q) begin
          rx_discard_q <= !first_ok && !rx_tlast;
        end
        rx_delimiter_reject <= orphan || (rx_first_q && rx_kind > KIND_RESPOND);
        if (fault_beat || bad_num) begin
          // close the broken frame with tlast and tuser
          rx_p_tdata          <= 64'h0;
          rx_p_tvalid         <= 1'b1;
          rx_p_tlast          <= 1'b1;
          rx_p_tuser          <= 1'b1;
          rx_asm_q            <= 1'b0;
          rx_reassembly_fault <= 1'b1;
        end
        if (rx_p_beat) begin
          rx_p_tdata  <= rx_tdata;
          rx_p_tvalid <= 1'b1;
          if (first_ok && is_start) begin
            rx_asm_q <= 1'b1;
            rx_exp_q <= 2'h1;
          end
          if (rx_tlast) begin
            // per fragment, fault and done indications
            rx_fragment_seen <= 1'b1;
            if (rx_frag_final || rx_tuser) begin
              rx_p_tlast          <= 1'b1;
              rx_p_tuser          <= rx_tuser;
              rx_asm_q            <= 1'b0;
              rx_reassembly_done  <= !rx_tuser;
              rx_reassembly_fault <= rx_tuser;
            end else if (is_cont) begin
              rx_exp_q <= rx_exp_q + 2'h1;
            end
          end
        end
      end
    end
  end

  // checks
  apb_one_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> $past(psel && penable && !pready))
    else $error("pready without an access phase");
  active_verified_a: assert property (@(posedge pclk) disable iff (!presetn)
    preempt_active && !noverify |-> verify_state == 2'b11 || $past(resp_q))
    else $error("preemption active without successful verification");
  express_first_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_p_tready && cur_q == SRC_IDLE |-> $past(!tx_e_tvalid || e_load))
    else $error("preemptable source chosen while express waited");
  ifg_ready_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    ifg_q != 4'h0 |-> !tx_e_tready && !tx_p_tready)
    else $error("source ready during inter-frame gap");
  hold_blocks_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_p_tready && !p_open_q |-> $past(!hold))
    else $error("preemptable frame started under hold");
  hold_seen_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(hold) |=> tx_hold_seen ##1 !tx_hold_seen)
    else $error("hold indication not a single pulse after rising hold");
  status_code_a: assert property (@(posedge pclk) disable iff (!presetn)
    verify_state[1] |-> verify_state[0])
    else $error("success reported without completion");
  tuser_last_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_p_tuser |-> rx_p_tlast && rx_p_tvalid)
    else $error("receive tuser without tlast");
  express_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_tvalid && rx_kind == KIND_EXPRESS |=> rx_e_tvalid && !rx_p_tvalid)
    else $error("express beat not steered to express output");
  restart_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(restart) && !noverify |=> vstate_q == V_SEND ##1 verify_state == 2'b00)
    else $error("restart did not begin verification");
  cut_rule_a: assert property (@(posedge pclk) disable iff (!presetn)
    p_load && frag_cut |-> preempt_active && (tx_e_tvalid || hold) && sent_after >= `MIN_FRAG_BYTES)
    else $error("fragment cut without allow conditions");

  verify_ok_c: cover property (@(posedge pclk) disable iff (!presetn) vstate_q == V_WAIT ##1 vstate_q == V_OK);
  preempt_c:   cover property (@(posedge pclk) disable iff (!presetn) p_load && frag_cut ##[1:20] e_load);
  rx_done_c:   cover property (@(posedge pclk) disable iff (!presetn) rx_reassembly_done);

endmodule : frame_preemption_merge

/* test/link_peer.sv */
// link partner: drains the transmit line, answers verify beats, plays receive beats
module link_peer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        slow,
  input  wire logic        answer,
  input  wire logic [63:0] tx_tdata,
  input  wire logic        tx_tvalid,
  input  wire logic        tx_tlast,
  input  wire logic        tx_tuser,
  input  wire logic [2:0]  tx_kind,
  input  wire logic [1:0]  tx_frag_num,
  output logic             tx_tready,
  output logic      [63:0] rx_tdata,
  output logic             rx_tvalid,
  output logic             rx_tlast,
  output logic      [2:0]  rx_kind,
  output logic      [1:0]  rx_frag_num,
  output logic             rx_frag_final
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [70:0] seen[$];
  logic [70:0] rxq[$];
  logic [70:0] b;
  logic [3:0]  tick = 4'h0;
  task automatic rx_beat(input logic [63:0] d, input logic [2:0] k, input logic [1:0] n, input logic l, input logic f);
    rxq.push_back({k, n, l, f, d});
  endtask : rx_beat
  initial begin
    tx_tready = 1'b0;
    rx_tvalid = 1'b0;
    {rx_kind, rx_frag_num, rx_tlast, rx_frag_final, rx_tdata} = '0;
  end
  always @(posedge pclk) begin
    tick <= tick + 4'h1;
    // a slow partner offers ready one cycle in four
    tx_tready <= presetn && (!slow || tick[1:0] == 2'h3);
    if (tx_tvalid && tx_tready) begin
      seen.push_back({tx_kind, tx_frag_num, tx_tlast, tx_tuser, tx_tdata});
      if (tx_kind == 3'h3 && answer) begin
        rxq.push_back({3'h4, 2'h0, 1'b1, 1'b1, 64'h0});
      end
    end
    rx_tvalid <= rxq.size() != 0;
    if (rxq.size() != 0) begin
      b = rxq.pop_front();
      {rx_kind, rx_frag_num, rx_tlast, rx_frag_final, rx_tdata} <= b;
    end else begin
      // idle data and last lines keep moving so a stale value never passes as data
      rx_tdata <= ~rx_tdata;
      rx_tlast <= ~rx_tlast;
    end
  end
endmodule : link_peer

/* test/frame_preemption_merge_test.sv */
// self-checking bench for the frame preemption merge block
`include "frame_preemption_merge_regs.svh"
module frame_preemption_merge_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, answer, rx_tuser;
  logic        tx_e_tvalid, tx_e_tlast, tx_e_tready, tx_p_tvalid, tx_p_tlast, tx_p_tready;
  logic        tx_tvalid, tx_tlast, tx_tuser, tx_tready, rx_tvalid, rx_tlast, rx_frag_final;
  logic        rx_e_tvalid, rx_e_tlast, rx_e_tuser, rx_p_tvalid, rx_p_tlast, rx_p_tuser;
  logic        tx_preemptable_sent, tx_continuation_sent, tx_hold_seen, rx_reassembly_fault;
  logic        rx_delimiter_reject, rx_reassembly_done, rx_fragment_seen;
  logic [1:0]  tx_frag_num, rx_frag_num, verify_state;
  logic [2:0]  tx_kind, rx_kind;
  logic [11:0] paddr;
  logic [15:0] tx_p_frame_bytes;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [63:0] tx_e_tdata, tx_p_tdata, tx_tdata, rx_tdata, rx_e_tdata, rx_p_tdata, d;
  logic [63:0] e_sent[$], p_sent[$];
  logic [65:0] exp_e[$], exp_p[$];
  logic [70:0] exp_t[$];
  int          n_errors, compares, p_cnt, n_pre, n_cont, n_hold, n_fault, n_rej, n_done, n_frag;
  frame_preemption_merge #(.MS_CYCLES(20)) u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .tx_e_tdata, .tx_e_tvalid, .tx_e_tlast, .tx_e_tready,
    .tx_p_tdata, .tx_p_tvalid, .tx_p_tlast, .tx_p_frame_bytes, .tx_p_tready,
    .tx_tdata, .tx_tvalid, .tx_tlast, .tx_tuser, .tx_kind, .tx_frag_num, .tx_tready,
    .rx_tdata, .rx_tvalid, .rx_tlast, .rx_tuser, .rx_kind, .rx_frag_num, .rx_frag_final,
    .rx_e_tdata, .rx_e_tvalid, .rx_e_tlast, .rx_e_tuser, .rx_p_tdata, .rx_p_tvalid, .rx_p_tlast, .rx_p_tuser,
    .verify_state, .tx_preemptable_sent, .tx_continuation_sent, .tx_hold_seen, .rx_reassembly_fault,
    .rx_delimiter_reject, .rx_reassembly_done, .rx_fragment_seen
  );
  link_peer u_peer (
    .pclk, .presetn, .slow, .answer, .tx_tdata, .tx_tvalid, .tx_tlast, .tx_tuser, .tx_kind,
    .tx_frag_num, .tx_tready, .rx_tdata, .rx_tvalid, .rx_tlast, .rx_kind, .rx_frag_num, .rx_frag_final
  );
  task automatic check(input logic [70:0] seen, input logic [70:0] want);
    compares++;
    if (seen !== want) begin
      n_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic end_of_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  task automatic rnd(output logic [63:0] r);
    seed = xs(seed);
    r[31:0] = seed;
    seed = xs(seed);
    r[63:32] = seed;
  endtask : rnd
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    check(71'(pslverr), 71'(err));
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic send_e(input int n);
    logic [63:0] v;
    for (int i = 0; i < n; i++) begin
      rnd(v);
      e_sent.push_back(v);
      tx_e_tdata <= v;
      tx_e_tvalid <= 1'b1;
      tx_e_tlast <= i == n - 1;
      @(negedge pclk);
      while (tx_e_tready !== 1'b1) @(negedge pclk);
      @(posedge pclk);
    end
    tx_e_tvalid <= 1'b0;
  endtask : send_e
  task automatic send_p(input int n, input logic [15:0] bytes);
    logic [63:0] v;
    for (int i = 0; i < n; i++) begin
      rnd(v);
      p_sent.push_back(v);
      p_cnt++;
      tx_p_tdata <= v;
      tx_p_tvalid <= 1'b1;
      tx_p_tlast <= i == n - 1;
      tx_p_frame_bytes <= bytes;
      @(negedge pclk);
      while (tx_p_tready !== 1'b1) @(negedge pclk);
      @(posedge pclk);
    end
    tx_p_tvalid <= 1'b0;
  endtask : send_p
  task automatic wait_vs(input logic [1:0] v);
    for (int i = 0; i < 400 && verify_state !== v; i++) @(negedge pclk);
    check(71'(verify_state), 71'(v));
    @(posedge pclk);
  endtask : wait_vs
  task automatic cmp_tx();
    repeat (60) @(posedge pclk);
    check(71'(u_peer.seen.size()), 71'(exp_t.size()));
    while (exp_t.size() != 0 && u_peer.seen.size() != 0) check(u_peer.seen.pop_front(), exp_t.pop_front());
    u_peer.seen.delete();
    exp_t.delete();
    e_sent.delete();
    p_sent.delete();
    p_cnt = 0;
  endtask : cmp_tx
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    #100000;
    n_errors++;
    end_of_test();
  end
  always @(negedge pclk) begin
    n_pre += int'(tx_preemptable_sent === 1'b1);
    n_cont += int'(tx_continuation_sent === 1'b1);
    n_hold += int'(tx_hold_seen === 1'b1);
    n_fault += int'(rx_reassembly_fault === 1'b1);
    n_rej += int'(rx_delimiter_reject === 1'b1);
    n_done += int'(rx_reassembly_done === 1'b1);
    n_frag += int'(rx_fragment_seen === 1'b1);
    // express output is accepted in every cycle
    if (rx_e_tvalid === 1'b1) check({rx_e_tlast, rx_e_tuser, rx_e_tdata}, exp_e.size() ? exp_e.pop_front() : 66'bx);
    if (rx_p_tvalid === 1'b1) check({rx_p_tlast, rx_p_tuser, rx_p_tdata}, exp_p.size() ? exp_p.pop_front() : 66'bx);
  end
  initial begin
    seed = 32'h0000_cda7;
    {psel, penable, pwrite, paddr, pwdata, slow, answer, rx_tuser} = '0;
    {tx_e_tvalid, tx_e_tlast, tx_e_tdata, tx_p_tvalid, tx_p_tlast, tx_p_tdata, tx_p_frame_bytes} = '0;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    check(71'({verify_state, tx_tvalid, pready, rx_p_tvalid, tx_hold_seen}), 71'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `CTRL_OFFSET, 32'h0, 1'b0);
    check(71'(rd), 71'(`CTRL_RESET));
    apb(1'b0, 12'h008, 32'h0, 1'b1);
    answer <= 1'b1;
    apb(1'b1, `CTRL_OFFSET, 32'h0003_0101, 1'b0);
    wait_vs(2'b11);
    check(71'(u_peer.seen[0][70:68]), 71'h3);
    u_peer.seen.delete();
    answer <= 1'b0;
    apb(1'b1, `CTRL_OFFSET, 32'h0002_0109, 1'b0);
    wait_vs(2'b01);
    check(71'(u_peer.seen.size()), 71'h2);
    u_peer.seen.delete();
    apb(1'b1, `CTRL_OFFSET, 32'h0002_0105, 1'b0);
    apb(1'b0, `STATUS_OFFSET, 32'h0, 1'b0);
    check(71'(rd[2]), 71'h1);
    n_pre = 0;
    fork
      send_e(1);
      send_p(8, 16'h0040);
    join
    exp_t.push_back({5'h0, 1'b1, 1'b0, e_sent[0]});
    for (int i = 0; i < 8; i++) exp_t.push_back({5'h4, (i == 7), 1'b0, p_sent[i]});
    cmp_tx();
    check(71'(n_pre), 71'h1);
    apb(1'b1, `CTRL_OFFSET, 32'h0002_0107, 1'b0);
    fork
      send_p(8, 16'h0040);
      begin
        repeat (30) @(posedge pclk);
        check(71'(p_cnt), 71'h1);
        apb(1'b1, `CTRL_OFFSET, 32'h0002_0105, 1'b0);
      end
    join
    for (int i = 0; i < 8; i++) exp_t.push_back({5'h4, (i == 7), 1'b0, p_sent[i]});
    cmp_tx();
    check(71'(n_hold), 71'h1);
    for (int s = 0; s < 4; s++) begin
      n_pre = 0;
      n_cont = 0;
      slow <= s[0];
      apb(1'b1, `CTRL_OFFSET, 32'h0002_0105 | 32'(s << 4), 1'b0);
      fork
        send_p(16 + 8 * s, 16'(128 + 64 * s));
        begin
          wait (p_cnt == 2);
          @(posedge pclk);
          send_e(1);
        end
      join
      for (int i = 0; i < 16 + 8 * s; i++) begin
        if (i == 8) exp_t.push_back({5'h0, 1'b1, 1'b0, e_sent[0]});
        exp_t.push_back({(i < 8 ? 5'h4 : 5'h9), (i == 7 || i == 15 + 8 * s), (i == 7), p_sent[i]});
      end
      cmp_tx();
      check(71'({n_pre, n_cont}), 71'h0000_0001_0000_0001);
    end
    rnd(d);
    exp_e.push_back({2'b10, d});
    u_peer.rx_beat(d, 3'h0, 2'h0, 1'b1, 1'b1);
    repeat (5) @(posedge pclk);
    {n_fault, n_rej, n_done, n_frag} = '0;
    for (int i = 0; i < 3; i++) begin
      rnd(d);
      exp_p.push_back({(i == 2), 1'b0, d});
      u_peer.rx_beat(d, i == 2 ? 3'h2 : 3'h1, 2'(i == 2), i > 0, i == 2);
    end
    repeat (10) @(posedge pclk);
    check(71'({n_done, n_frag}), 71'h0000_0001_0000_0002);
    u_peer.rx_beat(d, 3'h2, 2'h1, 1'b1, 1'b1);
    exp_p.push_back({2'b00, d});
    u_peer.rx_beat(d, 3'h1, 2'h0, 1'b1, 1'b0);
    exp_p.push_back({2'b11, 64'h0});
    u_peer.rx_beat(d, 3'h1, 2'h0, 1'b1, 1'b1);
    repeat (10) @(posedge pclk);
    check(71'({n_rej, n_fault}), 71'h0000_0001_0000_0001);
    check(71'(exp_e.size() + exp_p.size()), 71'h0);
    end_of_test();
  end
endmodule : frame_preemption_merge_test
